// >>> pmt_consts.svh
`ifndef PMT_CONSTS_SVH
`define PMT_CONSTS_SVH

`define PMT_XLEN            64
`define PMT_PHYS_WIDTH      56
`define PMT_VA48_BITS       48
`define PMT_VA57_BITS       57

`define PMT_CTRL_ADDR       8'h00
`define PMT_STATUS_ADDR     8'h04
`define PMT_CLEAR_ADDR      8'h08
`define PMT_IRQ_EN_ADDR     8'h0C
`define PMT_FAULT_LO_ADDR   8'h10
`define PMT_FAULT_HI_ADDR   8'h14
`define PMT_COUNT_ADDR      8'h18

`define PMT_CTRL_LEN_U_LSB  0
`define PMT_CTRL_LEN_S_LSB  2
`define PMT_CTRL_LEN_M_LSB  4
`define PMT_CTRL_MODPRIV    6
`define PMT_CTRL_PREV_LSB   7
`define PMT_CTRL_GUEST_PRIV 9
`define PMT_CTRL_MXR        10
`define PMT_CTRL_TMODE_LSB  11
`define PMT_CTRL_WIDTH      13

`define PMT_EV_PAGE_FAULT   0
`define PMT_EV_PHYS_INVALID 1
`define PMT_EV_RESERVED_LEN 2
`define PMT_EV_WIDTH        3

`define PMT_CTRL_RESET      32'h0000_0000
`define PMT_IRQ_EN_RESET    32'h0000_0000

`endif

// >>> pmt_pkg.sv
package pmt_pkg;
    typedef enum logic [1:0] {
        PMT_PRIV_U = 2'b00,
        PMT_PRIV_S = 2'b01,
        PMT_PRIV_R = 2'b10,
        PMT_PRIV_M = 2'b11
    } pmt_priv_type;

    typedef enum logic [1:0] {
        PMT_NO_TRANSLATION = 2'b00,
        PMT_PAGING_48BIT   = 2'b01,
        PMT_PAGING_57BIT   = 2'b10,
        PMT_TMODE_RSVD     = 2'b11
    } pmt_tmode_type;

    typedef enum logic [1:0] {
        PMT_LEN_OFF   = 2'b00,
        PMT_LEN_RSVD  = 2'b01,
        PMT_LEN_MINUS57 = 2'b10,
        PMT_LEN_MINUS48 = 2'b11
    } pmt_len_type;
endpackage : pmt_pkg

// >>> pmt_transform.sv
`timescale 1ns/10ps
`include "pmt_consts.svh"

module pmt_transform #(
    parameter int XLEN       = `PMT_XLEN,
    parameter int PHYS_WIDTH = `PMT_PHYS_WIDTH
) (
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic                      hreadyout,
    output logic      [31:0]          hrdata,
    output logic                      hresp,
    input  wire logic                 acc_valid,
    input  wire logic [XLEN-1:0]      acc_addr,
    input  wire logic                 acc_explicit,
    input  wire pmt_pkg::pmt_priv_type acc_priv,
    input  wire logic                 acc_guest,
    output logic                      out_valid,
    output logic      [XLEN-1:0]      out_addr,
    output logic                      out_page_fault,
    output logic                      out_phys_invalid,
    output logic                      irq
);
    import pmt_pkg::*;

    localparam int CNT_W = 32;

    // Supported tag widths follow the word width; each setting masks bits only while XLEN exceeds its address width (48 or 57)
    localparam int unsigned LEN48 = XLEN - `PMT_VA48_BITS;
    localparam int unsigned LEN57 = XLEN - `PMT_VA57_BITS;

    logic [`PMT_CTRL_WIDTH-1:0] ctrl;
    logic [`PMT_EV_WIDTH-1:0]   status;
    logic [`PMT_EV_WIDTH-1:0]   irq_en;
    logic [XLEN-1:0]            fault_addr;
    logic [CNT_W-1:0]           mask_count;

    logic                       dp_write;
    logic [7:0]                 dp_addr;
    logic                       ap_take;

    pmt_priv_type               eff_priv;
    pmt_tmode_type              tmode;
    pmt_len_type                len_sel;
    logic                       apply_mask;
    logic                       is_virtual;
    logic [XLEN-1:0]            next_addr;
    logic [`PMT_EV_WIDTH-1:0]   events;
    logic [`PMT_EV_WIDTH-1:0]   clr_bits;
    logic [31:0]                next_rdata;
    logic [31:0]                fault_lo;
    logic [31:0]                fault_hi;
    logic                       wr_ctrl;
    logic                       wr_irq_en;
    logic                       wr_clear;
    logic                       len_reserved;
    logic                       va_fault;
    logic                       pa_fault;
    logic                       check_on;
    logic                       fault_seen;
    logic                       mask_hit;

    // Number of masked bits for a supported setting; reserved settings mask nothing
    function automatic int unsigned mask_bits(input pmt_len_type sel);
        int unsigned n;
        n = 0;
        case (sel)
            PMT_LEN_MINUS48: n = LEN48;
            PMT_LEN_MINUS57: n = LEN57;
            default:         n = 0;
        endcase
        return n;
    endfunction : mask_bits

    // Virtual form: the masked field copies the highest kept bit
    function automatic logic [XLEN-1:0] sign_form(input logic [XLEN-1:0] a, input int unsigned n);
        logic [XLEN-1:0] r;
        r = a;
        for (int i = 0; i < XLEN; i++) begin
            if (i >= XLEN - n) begin
                r[i] = a[XLEN-1-n];
            end
        end
        return r;
    endfunction : sign_form

    // Physical form: the masked field is cleared
    function automatic logic [XLEN-1:0] zero_form(input logic [XLEN-1:0] a, input int unsigned n);
        logic [XLEN-1:0] r;
        r = a;
        for (int i = 0; i < XLEN; i++) begin
            if (i >= XLEN - n) begin
                r[i] = 1'b0;
            end
        end
        return r;
    endfunction : zero_form

    // Physical validity: nothing may be set at or above the implemented width
    function automatic logic phys_bad(input logic [XLEN-1:0] a);
        logic bad;
        bad = 1'b0;
        for (int i = 0; i < XLEN; i++) begin
            if (i >= PHYS_WIDTH && a[i]) begin
                bad = 1'b1;
            end
        end
        return bad;
    endfunction : phys_bad

    // Word-aligned offset compare; the two low address bits are ignored
    function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] offset);
        return {a[7:2], 2'b00} == offset;
    endfunction : reg_hit

    // Pure arithmetic on the address; mode and scheme enter only through virt
    function automatic logic [XLEN-1:0] ignore_xform(input logic [XLEN-1:0] a,
                                                     input int unsigned n,
                                                     input logic virt);
        logic [XLEN-1:0] r;
        r = a;
        if (n != 0) begin
            r = virt ? sign_form(a, n) : zero_form(a, n);
        end
        return r;
    endfunction : ignore_xform

    // Sign-extension check of the unused upper bits of a virtual address
    function automatic logic va_bad(input logic [XLEN-1:0] a, input int unsigned used);
        logic bad;
        bad = 1'b0;
        for (int i = 0; i < XLEN; i++) begin
            if (i >= used && a[i] != a[used-1]) begin
                bad = 1'b1;
            end
        end
        return bad;
    endfunction : va_bad

    // Settings of the effective privilege mode
    always_comb begin
        eff_priv = acc_priv;
        if (acc_guest) begin
            eff_priv = ctrl[`PMT_CTRL_GUEST_PRIV] ? PMT_PRIV_S : PMT_PRIV_U;
        end else if (acc_priv == PMT_PRIV_M && ctrl[`PMT_CTRL_MODPRIV]) begin
            eff_priv = pmt_priv_type'(ctrl[`PMT_CTRL_PREV_LSB+:2]);
        end
    end

    always_comb begin
        case (eff_priv)
            PMT_PRIV_M: len_sel = pmt_len_type'(ctrl[`PMT_CTRL_LEN_M_LSB+:2]);
            PMT_PRIV_S: len_sel = pmt_len_type'(ctrl[`PMT_CTRL_LEN_S_LSB+:2]);
            PMT_PRIV_U: len_sel = pmt_len_type'(ctrl[`PMT_CTRL_LEN_U_LSB+:2]);
            default:    len_sel = PMT_LEN_OFF;
        endcase
    end

    assign tmode = pmt_tmode_type'(ctrl[`PMT_CTRL_TMODE_LSB+:2]);

    // Machine mode counts as untranslated whatever the scheme says
    assign is_virtual = (eff_priv != PMT_PRIV_M) &&
                        (tmode == PMT_PAGING_48BIT || tmode == PMT_PAGING_57BIT);

    // Only explicit accesses, and never while executable pages read as readable
    assign apply_mask = acc_explicit &&
                        !ctrl[`PMT_CTRL_MXR] &&
                        (mask_bits(len_sel) != 0);

    // Done as an explicit sign or zero extension so it stays correct even when the
    // masked field reaches into the translated bits; checks below see the result
    always_comb begin
        next_addr = acc_addr;
        if (apply_mask) begin
            next_addr = ignore_xform(acc_addr, mask_bits(len_sel), is_virtual);
        end
    end

    // Zero-latency pass: the pipeline sees the result in the same cycle
    assign out_valid = acc_valid;
    assign out_addr  = next_addr;

    // Validity checks on the transformed address, as if software had untagged it
    assign check_on = acc_valid && acc_explicit;

    // Sign-extension check for whichever paging scheme is active
    always_comb begin
        va_fault = 1'b0;
        case (tmode)
            PMT_PAGING_48BIT: va_fault = va_bad(next_addr, `PMT_VA48_BITS);
            PMT_PAGING_57BIT: va_fault = va_bad(next_addr, `PMT_VA57_BITS);
            default:          va_fault = 1'b0;
        endcase
    end

    // Zero-extension check of an untranslated address
    always_comb begin
        pa_fault = phys_bad(next_addr);
    end

    // Only one form of check applies, chosen by the same test as the transform
    always_comb begin
        out_page_fault   = 1'b0;
        out_phys_invalid = 1'b0;
        if (check_on) begin
            if (is_virtual) begin
                out_page_fault = va_fault;
            end else begin
                out_phys_invalid = pa_fault;
            end
        end
    end

    // Reserved settings mask nothing but are flagged so software can notice
    assign len_reserved = (len_sel == PMT_LEN_RSVD);

    always_comb begin
        events = '0;
        events[`PMT_EV_PAGE_FAULT]   = out_page_fault;
        events[`PMT_EV_PHYS_INVALID] = out_phys_invalid;
        events[`PMT_EV_RESERVED_LEN] = check_on && len_reserved;
    end

    // AHB-Lite slave: zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign ap_take   = hsel && hready && htrans[1];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_write <= 1'b0;
            dp_addr  <= 8'h00;
        end else if (hready) begin
            dp_write <= ap_take && hwrite;
            dp_addr  <= haddr[7:0];
        end
    end

    // One strobe per writable register, decoded once from the data phase
    assign wr_ctrl   = dp_write && reg_hit(dp_addr, `PMT_CTRL_ADDR);
    assign wr_irq_en = dp_write && reg_hit(dp_addr, `PMT_IRQ_EN_ADDR);
    assign wr_clear  = dp_write && reg_hit(dp_addr, `PMT_CLEAR_ADDR);

    // The handler reads the wide fault address as two words
    assign fault_lo = fault_addr[31:0];
    assign fault_hi = fault_addr[63:32];

    // Read mux; the clear register holds no state and reads as zero
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (reg_hit(haddr[7:0], `PMT_CTRL_ADDR)) begin
            next_rdata = 32'(ctrl);
        end else if (reg_hit(haddr[7:0], `PMT_STATUS_ADDR)) begin
            next_rdata = 32'(status);
        end else if (reg_hit(haddr[7:0], `PMT_IRQ_EN_ADDR)) begin
            next_rdata = 32'(irq_en);
        end else if (reg_hit(haddr[7:0], `PMT_FAULT_LO_ADDR)) begin
            next_rdata = fault_lo;
        end else if (reg_hit(haddr[7:0], `PMT_FAULT_HI_ADDR)) begin
            next_rdata = fault_hi;
        end else if (reg_hit(haddr[7:0], `PMT_COUNT_ADDR)) begin
            next_rdata = mask_count;
        end
    end

    // Read data is latched in the address phase so it stands in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (ap_take && !hwrite) begin
            hrdata <= next_rdata;
        end
    end

    // Reset leaves masking and translation off, so addresses pass untouched
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl <= `PMT_CTRL_WIDTH'(`PMT_CTRL_RESET);
        end else if (wr_ctrl) begin
            ctrl <= hwdata[`PMT_CTRL_WIDTH-1:0];
        end
    end

    // Interrupts stay quiet until software opts in
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_en <= `PMT_EV_WIDTH'(`PMT_IRQ_EN_RESET);
        end else if (wr_irq_en) begin
            irq_en <= hwdata[`PMT_EV_WIDTH-1:0];
        end
    end

    // Clear acts only in the data phase of a write to the clear register
    assign clr_bits = wr_clear ? hwdata[`PMT_EV_WIDTH-1:0] : '0;

    // A new event in the clearing cycle survives the clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status <= '0;
        end else begin
            status <= (status & ~clr_bits) | events;
        end
    end

    // Last faulting transformed address, for the handler
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fault_addr <= '0;
        end else if (fault_seen) begin
            fault_addr <= next_addr;
        end
    end

    assign fault_seen = out_page_fault || out_phys_invalid;

    // Counts accesses the transform was applied to; wraps silently
    assign mask_hit = acc_valid && apply_mask;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mask_count <= '0;
        end else if (mask_hit) begin
            mask_count <= mask_count + CNT_W'(1);
        end
    end

    // Level output straight from registers, so the access path cannot glitch it
    assign irq = |(status & irq_en);

endmodule : pmt_transform

// >>> pmt_transform_monitor.sv
`timescale 1ns/10ps
module pmt_transform_monitor #(
    parameter int XLEN       = 64,
    parameter int PHYS_WIDTH = 56
) (
    input  wire logic            hclk,
    input  wire logic            hresetn,
    input  wire logic            hreadyout,
    input  wire logic            hresp,
    input  wire logic            acc_valid,
    input  wire logic [XLEN-1:0] acc_addr,
    input  wire logic            acc_explicit,
    input  wire logic            out_valid,
    input  wire logic [XLEN-1:0] out_addr,
    input  wire logic            out_page_fault,
    input  wire logic            out_phys_invalid
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    valid_echo_a: assert property ($rose(acc_valid) |-> $rose(out_valid)) else $error("valid not echoed");
    implicit_pass_a: assert property (acc_valid && !acc_explicit |-> out_addr == acc_addr)
        else $error("implicit address changed");
    low_keep_a: assert property (acc_valid |-> out_addr[XLEN-17:0] == acc_addr[XLEN-17:0])
        else $error("low bits changed");
    top_form_a: assert property (acc_valid |-> out_addr == acc_addr || out_addr[XLEN-1:XLEN-7] == '0
        || out_addr[XLEN-1:XLEN-7] == {7{out_addr[XLEN-8]}}) else $error("top bits malformed");
    fault_cause_a: assert property (acc_valid && out_page_fault |-> acc_explicit
        && out_addr[XLEN-1:47] != {(XLEN-47){out_addr[47]}}) else $error("page fault without cause");
    phys_cause_a: assert property (acc_valid && out_phys_invalid |-> acc_explicit
        && |out_addr[XLEN-1:PHYS_WIDTH]) else $error("phys invalid without cause");
    one_kind_a: assert property (acc_valid |-> !(out_page_fault && out_phys_invalid))
        else $error("both fault kinds");
    bus_okay_a: assert property (hreadyout && !hresp) else $error("bus not ready or okay");
endmodule : pmt_transform_monitor

bind pmt_transform pmt_transform_monitor #(.XLEN(XLEN), .PHYS_WIDTH(PHYS_WIDTH)) i_mon (.hclk, .hresetn,
    .hreadyout, .hresp, .acc_valid, .acc_addr, .acc_explicit, .out_valid, .out_addr, .out_page_fault,
    .out_phys_invalid);

// >>> pmt_mem_sink.sv
`timescale 1ns/10ps
module pmt_mem_sink (
    input  wire logic        hclk,
    input  wire logic        req_valid,
    input  wire logic [63:0] req_addr,
    output logic      [63:0] last_addr
);
    // Takes the address in its own cycle; it never stalls the access path
    always_ff @(posedge hclk) begin
        if (req_valid) begin
            last_addr <= req_addr;
        end
    end
endmodule : pmt_mem_sink

// >>> pointer_tag_masking_transform_tb.sv
`timescale 1ns/10ps
`include "pmt_consts.svh"
module pointer_tag_masking_transform_tb;
    import pmt_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, acc_valid, acc_explicit, acc_guest, irq;
    logic out_valid, out_page_fault, out_phys_invalid;
    logic [31:0] haddr, hwdata, hrdata;
    logic [63:0] acc_addr, out_addr, sink_addr;
    logic [1:0]  htrans;
    logic [2:0]  exp_st;
    logic [63:0] exp_fault;
    logic [31:0] exp_cnt;
    logic [2:0]  hsize;
    pmt_priv_type acc_priv;
    int fails, checks_done;
    pmt_transform i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
        .hreadyout, .hrdata, .hresp, .acc_valid, .acc_addr, .acc_explicit, .acc_priv, .acc_guest, .out_valid,
        .out_addr, .out_page_fault, .out_phys_invalid, .irq);
    pmt_mem_sink i_sink (.hclk, .req_valid(out_valid), .req_addr(out_addr), .last_addr(sink_addr));
    initial begin
        hclk = 0;
        forever #5 hclk = ~hclk;
    end
    task automatic close_out;
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out
    task automatic cmp(string name, logic [63:0] exp, logic [63:0] got);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : cmp
    task automatic wait_rdy;
        int n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (n >= 50) begin
            fails++;
            close_out();
        end
    endtask : wait_rdy
    // Bus is idle one cycle between calls, so a read sees an earlier write
    task automatic bus(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1;
        haddr <= 32'(a);
        htrans <= 2'h2;
        hwrite <= w;
        wait_rdy();
        htrans <= 2'h0;
        hsel <= 0;
        hwdata <= d;
        wait_rdy();
        r = hrdata;
    endtask : bus
    function automatic logic [67:0] model(logic [12:0] c, logic [63:0] a, logic e, logic [1:0] p, logic g);
        logic [1:0]  ep;
        logic [1:0]  len;
        logic        virt;
        int          n;
        logic [63:0] r;
        ep = g ? {1'b0, c[9]} : (p == 2'h3 && c[6]) ? c[8:7] : p;
        len = c[(ep == 2'h3 ? 4 : 2 * ep) +: 2];
        virt = ep != 2'h3 && (c[12:11] == 2'h1 || c[12:11] == 2'h2);
        n = (!e || c[10]) ? 0 : (len == 2'h3) ? 16 : (len == 2'h2) ? 7 : 0;
        r = a;
        for (int i = 0; i < n; i++) begin
            r[63 - i] = virt & a[63 - n];
        end
        return {n != 0, e && len == 2'h1, e && virt && (c[11] ? r[63:47] != {17{r[47]}} : r[63:56] != {8{r[56]}}),
            e && !virt && (|r[63:56]), r};
    endfunction : model
    task automatic access(logic [12:0] c, logic [63:0] a, logic e, logic [1:0] p, logic g);
        logic [31:0] r;
        logic [67:0] ex;
        bus(1, `PMT_CTRL_ADDR, 32'(c), r);
        @(posedge hclk);
        acc_valid <= 1;
        acc_addr <= a;
        acc_explicit <= e;
        acc_priv <= pmt_priv_type'(p);
        acc_guest <= g;
        @(negedge hclk);
        ex = model(c, a, e, p, g);
        cmp("out_addr", ex[63:0], out_addr);
        cmp("page_fault", ex[65], out_page_fault);
        cmp("phys_invalid", ex[64], out_phys_invalid);
        cmp("out_valid", 1, out_valid);
        exp_st |= {ex[66], ex[64], ex[65]};
        exp_cnt += 32'(ex[67]);
        if (ex[65] || ex[64]) begin
            exp_fault = ex[63:0];
        end
        @(posedge hclk);
        acc_valid <= 0;
        #1 cmp("sink addr", ex[63:0], sink_addr);
    endtask : access
    initial begin
        logic [31:0] r;
        logic [12:0] c;
        logic [63:0] a;
        logic [1:0]  p;
        logic        e;
        logic        g;
        void'($urandom(32'hb757));
        {hresetn, hsel, haddr, htrans, hwrite, hwdata, acc_valid, acc_addr, acc_explicit, acc_guest} = '0;
        {fails, checks_done, exp_st} = '0;
        exp_fault = '0;
        exp_cnt = '0;
        hsize = 3'h2;
        acc_priv = PMT_PRIV_U;
        repeat (4) @(posedge hclk);
        hresetn <= 1;
        bus(0, `PMT_CTRL_ADDR, 0, r);
        cmp("ctrl reset", `PMT_CTRL_RESET, r);
        bus(0, `PMT_IRQ_EN_ADDR, 0, r);
        cmp("irq_en reset", `PMT_IRQ_EN_RESET, r);
        bus(0, 8'h1C, 0, r);
        cmp("unmapped", 0, r);
        bus(1, `PMT_CLEAR_ADDR, 32'h0000_0007, r);
        $display("test registers done");
        access(13'h0803, 64'hABCD_8000_1234_5678, 1, 0, 0);
        access(13'h1020, 64'hFE00_0000_0000_1000, 1, 3, 0);
        access(13'h0C03, 64'h1234_0000_0000_0000, 1, 0, 0);
        access(13'h0803, 64'hFFFF_0000_0000_0000, 0, 0, 0);
        access(13'h0001, 64'h0F00_0000_0000_0000, 1, 0, 0);
        access(13'h10CC, 64'h5A00_1234_0000_0040, 1, 3, 0);
        access(13'h0A08, 64'h7700_0000_0000_0008, 1, 0, 1);
        $display("test corners done");
        repeat (300) begin
            c = 13'($urandom);
            c[7] = c[7] | c[8];
            a = {$urandom, $urandom};
            if ($urandom % 2) a[63:40] = {24{a[39]}};
            p = 2'($urandom % 3);
            p = p | {1'b0, p[1]};
            e = 1'($urandom);
            g = ($urandom % 4) == 0;
            access(c, a, e, p, g);
        end
        $display("test transform done");
        bus(0, `PMT_COUNT_ADDR, 0, r);
        cmp("mask count", exp_cnt, r);
        bus(0, `PMT_FAULT_LO_ADDR, 0, r);
        cmp("fault lo", exp_fault[31:0], r);
        bus(0, `PMT_FAULT_HI_ADDR, 0, r);
        cmp("fault hi", exp_fault[63:32], r);
        bus(0, `PMT_STATUS_ADDR, 0, r);
        cmp("status", exp_st, r[2:0]);
        cmp("irq masked", 0, irq);
        bus(1, `PMT_IRQ_EN_ADDR, 32'h0000_0003, r);
        @(negedge hclk);
        cmp("irq raised", |exp_st, irq);
        bus(1, `PMT_CLEAR_ADDR, 32'h0000_0003, r);
        @(negedge hclk);
        cmp("irq cleared", 0, irq);
        $display("test interrupt done");
        close_out();
    end
endmodule : pointer_tag_masking_transform_tb
